// file: rtl/pcg2_pkg.sv
// Constants and carrier types for the group-two peripheral clock gating block
`default_nettype none
package pcg2_pkg;

  // Register byte offsets from the system-control base
  localparam logic [11:0] RUN_GATE_OFF   = 12'h108;
  localparam logic [11:0] SLEEP_GATE_OFF = 12'h118;
  localparam logic [11:0] DEEP_GATE_OFF  = 12'h128;
  localparam logic [11:0] CLK_CFG_OFF    = 12'h150;
  localparam logic [11:0] IRQ_STAT_OFF   = 12'h154;
  localparam logic [11:0] IRQ_EN_OFF     = 12'h158;
  localparam logic [11:0] IRQ_CLR_OFF    = 12'h15C;

  // Field positions inside every gating word, and of the select bit in the configuration word
  localparam int USB_BIT    = 16;
  localparam int DMA_BIT    = 13;
  localparam int PORT_E_BIT = 4;
  localparam int PORT_A_BIT = 0;
  localparam int ACG_BIT    = 0;

  // Writable bits of a gating word; the rest read as zero
  localparam logic [31:0] GATE_MASK  = 32'h0001_201F;
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_MASK   = 32'h0000_0001;
  localparam logic [31:0] CFG_RESET  = 32'h0000_0000;

  // Unit numbering on the access-check port
  localparam int          UNIT_COUNT = 7;
  localparam logic [2:0]  UNIT_DMA   = 3'h5;
  localparam logic [2:0]  UNIT_USB   = 3'h6;

  // Power modes, Gray coded along run -> sleep -> deep sleep
  typedef enum logic [1:0] {
    PCG2_RUN   = 2'h0,
    PCG2_SLEEP = 2'h1,
    PCG2_DEEP  = 2'h3
  } pcg2_mode_e;

  // Gating word layout
  typedef struct packed {
    logic [14:0] rsvdHigh;
    logic        serialBusControllerGate;
    logic [1:0]  rsvdMid;
    logic        microDmaGate;
    logic [7:0]  rsvdLow;
    logic        portEGate;
    logic        portDGate;
    logic        portCGate;
    logic        portBGate;
    logic        portAGate;
  } pcg2_gate_s;

  // Unit access check request
  typedef struct packed {
    logic       valid;
    logic [2:0] unit;
  } pcg2_access_s;

endpackage
`default_nettype wire

// file: rtl/pcg2_clock_gate.sv
// Group-two peripheral clock gating control with Wishbone register slave
//
// Functional notes
// R01: A gating bit of 1 lets its unit's clock run, a 0 holds it stopped.
// R02: An access to a unit whose clock is stopped ends in a bus fault.
// R03: Every gating bit is 0 after reset so all units start unclocked.
// R04: Run mode uses the run gating word, sleep mode the sleep word.
// R05: Sleep words apply only while the auto clock gating select bit is 1.
// R06: USB gate is bit 16, micro-DMA bit 13, ports E..A bits 4..0.
// R07: Reserved bits are read-only zero and software keeps them on update.
// R08: Run word sits at offset 0x108 and sleep word at 0x118.
// R09: A deep-sleep word of the same layout at 0x128 governs deep sleep.
// R10: Enables change only at clock edges so gating cells never glitch.
`default_nettype none
module pcg2_clock_gate
(
  // Clock and reset
  input  wire  logic                  clk,
  input  wire  logic                  sys_rst,
  // Wishbone classic slave
  input  wire  logic                  wb_cyc_i,
  input  wire  logic                  wb_stb_i,
  input  wire  logic                  wb_we_i,
  input  wire  logic [11:0]           wb_adr_i,
  input  wire  logic [3:0]            wb_sel_i,
  input  wire  logic [31:0]           wb_dat_i,
  output logic       [31:0]           wb_dat_o,
  output logic                        wb_ack_o,
  // Power mode requests from the system
  input  wire  logic                  sleepReq,
  input  wire  logic                  deepSleepReq,
  // Unit access check from the peripheral bus
  input  wire  pcg2_pkg::pcg2_access_s accessReq,
  output logic                        accessFault,
  output logic                        accessOk,
  // Clock enables for the units' gating cells
  output pcg2_pkg::pcg2_gate_s        unitClkEn,
  // Interrupt
  output logic                        irq
);

  // Register state
  logic [31:0]          runGate_r;
  logic [31:0]          sleepGate_r;
  logic [31:0]          deepGate_r;
  logic [31:0]          clkCfg_r;
  logic [31:0]          irqStat_r;
  logic [31:0]          irqEn_r;
  pcg2_pkg::pcg2_mode_e mode_r;
  pcg2_pkg::pcg2_mode_e mode_nxt;
  logic [31:0]          effGate;
  logic                 busReq;
  logic                 wrStrobe;
  logic [31:0]          rdData;
  logic [31:0]          faultSet;
  logic [31:0]          clrBits;

  // Byte-lane merge of write data into a register
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  sel,
                                            input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & mask;
    laneMerge = (old & ~m) | (data & m);
  endfunction

  // Gating-word bit that belongs to an access-port unit number
  function automatic logic [31:0] unitBit(input logic [2:0] unit);
    if (unit == pcg2_pkg::UNIT_USB)
      unitBit = 32'h0000_0001 << pcg2_pkg::USB_BIT;
    else if (unit == pcg2_pkg::UNIT_DMA)
      unitBit = 32'h0000_0001 << pcg2_pkg::DMA_BIT;
    else if (unit <= 3'(pcg2_pkg::PORT_E_BIT))
      unitBit = 32'h0000_0001 << unit;
    else
      unitBit = 32'h0000_0000;
  endfunction

  // Bus request decode; ack is held off one cycle so each access is single
  assign busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrStrobe = busReq & wb_we_i;

  // Power mode follows the system request; deep sleep outranks sleep
  always_comb
  begin
    if (deepSleepReq)
      mode_nxt = pcg2_pkg::PCG2_DEEP;
    else if (sleepReq)
      mode_nxt = pcg2_pkg::PCG2_SLEEP;
    else
      mode_nxt = pcg2_pkg::PCG2_RUN;
  end

  // Mode register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mode_r <= pcg2_pkg::PCG2_RUN;
    else
      mode_r <= mode_nxt;
  end

  // Word in force: run word unless auto gating selects a sleep word
  always_comb
  begin
    case (mode_r)
      pcg2_pkg::PCG2_RUN:   effGate = runGate_r; // R04
      pcg2_pkg::PCG2_SLEEP: effGate = clkCfg_r[pcg2_pkg::ACG_BIT]
                                      ? sleepGate_r : runGate_r; // R05
      pcg2_pkg::PCG2_DEEP:  effGate = clkCfg_r[pcg2_pkg::ACG_BIT]
                                      ? deepGate_r : runGate_r; // R09
      default:              effGate = runGate_r;
    endcase
  end

  // Registered enables feed latch-based gating cells, one edge late
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      unitClkEn <= pcg2_pkg::GATE_RESET; // R03
    else
      unitClkEn <= effGate & pcg2_pkg::GATE_MASK; // R01 R06 R10
  end

  // Gating words; only the documented bits can ever be set
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      runGate_r   <= pcg2_pkg::GATE_RESET; // R03
      sleepGate_r <= pcg2_pkg::GATE_RESET;
      deepGate_r  <= pcg2_pkg::GATE_RESET;
    end
    else if (wrStrobe)
    begin
      if (wb_adr_i == pcg2_pkg::RUN_GATE_OFF) // R08
        runGate_r <= laneMerge(runGate_r, wb_dat_i, wb_sel_i,
                               pcg2_pkg::GATE_MASK); // R07
      if (wb_adr_i == pcg2_pkg::SLEEP_GATE_OFF) // R08
        sleepGate_r <= laneMerge(sleepGate_r, wb_dat_i, wb_sel_i,
                                 pcg2_pkg::GATE_MASK);
      if (wb_adr_i == pcg2_pkg::DEEP_GATE_OFF) // R09
        deepGate_r <= laneMerge(deepGate_r, wb_dat_i, wb_sel_i,
                                pcg2_pkg::GATE_MASK);
    end
  end

  // Configuration word holding the auto clock gating select bit
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      clkCfg_r <= pcg2_pkg::CFG_RESET;
    else if (wrStrobe && wb_adr_i == pcg2_pkg::CLK_CFG_OFF)
      clkCfg_r <= laneMerge(clkCfg_r, wb_dat_i, wb_sel_i,
                            pcg2_pkg::CFG_MASK); // R05
  end

  // Access check against the enables the unit actually sees
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      accessFault <= 1'b0;
      accessOk    <= 1'b0;
    end
    else
    begin
      accessFault <= accessReq.valid
                     & ~|(unitBit(accessReq.unit) & unitClkEn); // R02
      accessOk    <= accessReq.valid
                     & |(unitBit(accessReq.unit) & unitClkEn);
    end
  end

  // Fault events per unit, in gating-word layout
  assign faultSet = (accessReq.valid & ~|(unitBit(accessReq.unit) & unitClkEn))
                    ? unitBit(accessReq.unit) : 32'h0000_0000;
  assign clrBits  = (wrStrobe && wb_adr_i == pcg2_pkg::IRQ_CLR_OFF)
                    ? laneMerge(32'h0000_0000, wb_dat_i, wb_sel_i,
                                pcg2_pkg::GATE_MASK) : 32'h0000_0000;

  // Sticky status; a new fault wins over a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irqStat_r <= 32'h0000_0000;
    else
      irqStat_r <= (irqStat_r & ~clrBits) | faultSet;
  end

  // Interrupt enable word
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irqEn_r <= 32'h0000_0000;
    else if (wrStrobe && wb_adr_i == pcg2_pkg::IRQ_EN_OFF)
      irqEn_r <= laneMerge(irqEn_r, wb_dat_i, wb_sel_i, pcg2_pkg::GATE_MASK);
  end

  // Level interrupt, registered so it is a clean flop output
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(((irqStat_r & ~clrBits) | faultSet) & irqEn_r);
  end

  // Read mux; unmapped and write-only offsets read zero
  always_comb
  begin
    case (wb_adr_i)
      pcg2_pkg::RUN_GATE_OFF:   rdData = runGate_r;
      pcg2_pkg::SLEEP_GATE_OFF: rdData = sleepGate_r;
      pcg2_pkg::DEEP_GATE_OFF:  rdData = deepGate_r;
      pcg2_pkg::CLK_CFG_OFF:    rdData = clkCfg_r;
      pcg2_pkg::IRQ_STAT_OFF:   rdData = irqStat_r;
      pcg2_pkg::IRQ_EN_OFF:     rdData = irqEn_r;
      default:                  rdData = 32'h0000_0000;
    endcase
  end

  // Bus answer one cycle after the request, for one cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= busReq;
      wb_dat_o <= (busReq & ~wb_we_i) ? rdData : 32'h0000_0000;
    end
  end

  // Checks
  sequence busAsk_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ackPulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  reset_zero_a: assert property (@(posedge clk) // R03
    $past(sys_rst) |-> (unitClkEn == 32'h0 && runGate_r == 32'h0
                        && sleepGate_r == 32'h0 && deepGate_r == 32'h0))
    else $error("Gating state not zero after reset");

  enable_follow_a: assert property (@(posedge clk) disable iff (sys_rst) // R01
    ##1 !$past(sys_rst) |-> unitClkEn == ($past(effGate) & 32'h0001_201F))
    else $error("Unit enables do not follow the word in force");

  gated_fault_a: assert property (@(posedge clk) disable iff (sys_rst) // R02
    accessReq.valid && !(|(unitBit(accessReq.unit) & unitClkEn))
    |=> accessFault && !accessOk)
    else $error("Access to stopped unit did not fault");

  open_access_a: assert property (@(posedge clk) disable iff (sys_rst) // R02
    accessReq.valid && (|(unitBit(accessReq.unit) & unitClkEn))
    |=> accessOk && !accessFault)
    else $error("Access to running unit faulted");

  sleep_select_a: assert property (@(posedge clk) disable iff (sys_rst) // R05
    mode_r == pcg2_pkg::PCG2_SLEEP && !clkCfg_r[0] |-> effGate == runGate_r)
    else $error("Sleep word used without auto gating select");

  sleep_word_a: assert property (@(posedge clk) disable iff (sys_rst) // R04
    sleepReq && !deepSleepReq && clkCfg_r[0] ##1 clkCfg_r[0]
    |-> effGate == sleepGate_r)
    else $error("Sleep mode not using sleep word");

  deep_word_a: assert property (@(posedge clk) disable iff (sys_rst) // R09
    deepSleepReq && clkCfg_r[0] ##1 clkCfg_r[0] |-> effGate == deepGate_r)
    else $error("Deep sleep not using deep-sleep word");

  reserved_zero_a: assert property (@(posedge clk) disable iff (sys_rst) // R07
    (runGate_r | sleepGate_r | deepGate_r) == ((runGate_r | sleepGate_r
     | deepGate_r) & 32'h0001_201F))
    else $error("Reserved gating bit set");

  run_read_a: assert property (@(posedge clk) disable iff (sys_rst) // R08
    busAsk_s and (!wb_we_i && wb_adr_i == 12'h108) |=> ackPulse_s
    and (wb_dat_o == $past(runGate_r)))
    else $error("Run word read at 0x108 wrong");

  usb_bit_a: assert property (@(posedge clk) disable iff (sys_rst) // R06
    accessReq.valid && accessReq.unit == 3'h6 && !unitClkEn[16]
    |=> accessFault)
    else $error("USB gate not at bit 16");

  edge_only_a: assert property (@(posedge clk) disable iff (sys_rst) // R10
    $changed(unitClkEn) |-> $past(effGate & 32'h0001_201F) != $past(unitClkEn))
    else $error("Enable changed without a cause");

  // A fault on a mapped unit must leave its sticky status bit set
  status_set_a: assert property (@(posedge clk) disable iff (sys_rst) // R02
    accessReq.valid && accessReq.unit != 3'h7
    && !(|(unitBit(accessReq.unit) & unitClkEn))
    |=> |(irqStat_r & $past(unitBit(accessReq.unit))))
    else $error("Fault status bit not set");

endmodule
`default_nettype wire

// file: verification/pcg2_clock_gate_bench.sv
// Self-checking bench for the group-two clock gating block
`default_nettype none
module pcg2_clock_gate_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic                   clk;
  logic                   sysRst;
  logic                   wbCyc;
  logic                   wbStb;
  logic                   wbWe;
  logic [11:0]            wbAdr;
  logic [3:0]             wbSel;
  logic [31:0]            wbDatW;
  logic [31:0]            wbDatR;
  logic                   wbAck;
  logic                   sleepReq;
  logic                   deepSleepReq;
  pcg2_pkg::pcg2_access_s accessReq;
  logic                   accessFault;
  logic                   accessOk;
  pcg2_pkg::pcg2_gate_s   unitClkEn;
  logic                   irq;
  int                     fails;
  int                     checks;
  logic [31:0]            rdData;

  // Unit number to gating bit; -1 marks the unit with no gate
  int                     posTab [8] = '{0, 1, 2, 3, 4, 13, 16, -1};

  pcg2_clock_gate dut
  (
    .clk          (clk),
    .sys_rst      (sysRst),
    .wb_cyc_i     (wbCyc),
    .wb_stb_i     (wbStb),
    .wb_we_i      (wbWe),
    .wb_adr_i     (wbAdr),
    .wb_sel_i     (wbSel),
    .wb_dat_i     (wbDatW),
    .wb_dat_o     (wbDatR),
    .wb_ack_o     (wbAck),
    .sleepReq     (sleepReq),
    .deepSleepReq (deepSleepReq),
    .accessReq    (accessReq),
    .accessFault  (accessFault),
    .accessOk     (accessOk),
    .unitClkEn    (unitClkEn),
    .irq          (irq)
  );

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Classic cycle: hold the request until ack is sampled high
  task automatic wbAccess(input logic we, input logic [11:0] adr,
                          input logic [31:0] dat, input logic [3:0] sel);
    int n;
    @(posedge clk);
    {wbCyc, wbStb, wbWe} <= {2'b11, we};
    wbAdr <= adr;
    wbSel <= sel;
    wbDatW <= dat;
    for (n = 0; n < 16 && wbAck !== 1'b1; n++)
      @(posedge clk);
    if (n == 16)
    begin
      fails++;
      final_report();
    end
    rdData = wbDatR;
    {wbCyc, wbStb, wbWe} <= 3'h0;
  endtask

  task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
    wbAccess(1'b1, adr, dat, 4'hF);
  endtask

  task automatic rdChk(input logic [11:0] adr, input logic [31:0] exp);
    wbAccess(1'b0, adr, 32'h0000_0000, 4'hF);
    check($sformatf("reg %h", adr), rdData, exp);
  endtask

  // Mode changes land a cycle after their request and enables a cycle after that
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // One access probe per unit, answer looked at in its single cycle
  task automatic probe(input logic [2:0] u, input logic [31:0] w);
    logic f;
    f = (posTab[u] < 0) ? 1'b1 : ~w[posTab[u]];
    @(posedge clk) accessReq <= '{valid: 1'b1, unit: u};
    @(posedge clk) accessReq <= '{valid: 1'b0, unit: 3'h0};
    #1;
    check($sformatf("fault/ok unit %0d", u), {accessFault, accessOk},
          {30'h0, f, ~f});
  endtask

  task automatic probeAll(input logic [31:0] w);
    for (int u = 0; u < 8; u++)
      probe(3'(u), w);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {sysRst, wbCyc, wbStb, wbWe, sleepReq, deepSleepReq} = 6'h20;
    {wbAdr, wbSel, wbDatW} = '0;
    accessReq = '{valid: 1'b0, unit: 3'h0};
    fails = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    sysRst <= 1'b0;
    settle();
    check("unitClkEn", unitClkEn, 32'h0000_0000);
    rdChk(12'h108, 32'h0000_0000);
    rdChk(12'h118, 32'h0000_0000);
    rdChk(12'h128, 32'h0000_0000);
    $display("test reset done");
    // Reserved bits and byte lanes
    wr(12'h108, 32'hFFFF_FFFF);
    rdChk(12'h108, 32'h0001_201F);
    settle();
    check("unitClkEn", unitClkEn, 32'h0001_201F);
    wbAccess(1'b1, 12'h108, 32'h0000_0000, 4'h4);
    rdChk(12'h108, 32'h0000_201F);
    wr(12'h200, 32'hFFFF_FFFF);
    rdChk(12'h200, 32'h0000_0000);
    probeAll(32'h0000_201F);
    wr(12'h108, 32'h0001_0005);
    probeAll(32'h0001_0005);
    $display("test run gating done");
    // Sleep words only count with the select bit set
    wr(12'h118, 32'h0000_2012);
    wr(12'h128, 32'h0001_0008);
    @(posedge clk) sleepReq <= 1'b1;
    settle();
    check("unitClkEn", unitClkEn, 32'h0001_0005);
    wr(12'h150, 32'h0000_0001);
    rdChk(12'h150, 32'h0000_0001);
    settle();
    check("unitClkEn", unitClkEn, 32'h0000_2012);
    probeAll(32'h0000_2012);
    @(posedge clk) deepSleepReq <= 1'b1;
    settle();
    check("unitClkEn", unitClkEn, 32'h0001_0008);
    @(posedge clk) {sleepReq, deepSleepReq} <= 2'b00;
    settle();
    check("unitClkEn", unitClkEn, 32'h0001_0005);
    $display("test modes done");
    // Fault status, enable, clear and mask
    // Earlier probes left faults of units 0..6 sticky; clear them first
    rdChk(12'h154, 32'h0001_201F);
    wr(12'h15C, 32'hFFFF_FFFF);
    rdChk(12'h154, 32'h0000_0000);
    wr(12'h158, 32'h0000_0002);
    rdChk(12'h158, 32'h0000_0002);
    probe(3'h1, 32'h0001_0005);
    settle();
    check("irq", {31'h0, irq}, 32'h0000_0001);
    rdChk(12'h154, 32'h0000_0002);
    wr(12'h15C, 32'h0000_0002);
    settle();
    check("irq", {31'h0, irq}, 32'h0000_0000);
    rdChk(12'h154, 32'h0000_0000);
    probe(3'h3, 32'h0001_0005);
    settle();
    check("irq", {31'h0, irq}, 32'h0000_0000);
    rdChk(12'h154, 32'h0000_0008);
    $display("test interrupt done");
    final_report();
  end
endmodule
`default_nettype wire
